// >>> hdl/dehm_pkg.sv
`default_nettype none
package dehm_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned MS_NS         = 1_000_000;
   localparam int unsigned CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
   localparam logic [23:0] PHASE_WRAP    = 24'h989680;  // Clock rate in Hz

   // ----------------------------------------
   // Step smoothing filter
   // ----------------------------------------
   localparam logic [11:0] FILT_HZ_MAX = 12'h9C4;  // 2500 Hz
   localparam logic [11:0] FILT_HZ_RST = 12'h000;
   localparam logic [7:0]  SUB_STEPS   = 8'h04;    // Fine pulses per coarse step

   // ----------------------------------------
   // Enable usage codes and I/O points
   // ----------------------------------------
   localparam logic [2:0] USE_MAIN_OPEN   = 3'h1;
   localparam logic [2:0] USE_MAIN_CLOSED = 3'h2;
   localparam logic [2:0] USE_NONE        = 3'h3;
   localparam logic [2:0] USE_ALT_OPEN    = 3'h4;
   localparam logic [2:0] USE_ALT_CLOSED  = 3'h5;
   localparam logic [1:0] PT_NONE         = 2'h0;
   localparam logic [1:0] PT_ONE          = 2'h1;
   localparam logic [1:0] PT_THREE        = 2'h3;

   // ----------------------------------------
   // Speed-change control modes, alarm-reset usage
   // ----------------------------------------
   localparam logic [4:0] CM_SPD_A  = 5'h0D;
   localparam logic [4:0] CM_SPD_B  = 5'h0E;
   localparam logic [4:0] CM_SPD_C  = 5'h11;
   localparam logic [4:0] CM_SPD_D  = 5'h12;
   localparam logic [1:0] AR_OPEN   = 2'h1;
   localparam logic [1:0] AR_CLOSED = 2'h2;
   localparam logic [1:0] AR_FREE   = 2'h3;

   typedef enum logic [1:0] {DEHM_LOW, DEHM_HIGH, DEHM_FALL, DEHM_RISE} dehm_cond_e;
endpackage : dehm_pkg
`default_nettype wire

// >>> hdl/dehm_home_if.sv
`default_nettype none
interface dehm_home_if;
   logic        start;
   logic        dir_neg;
   logic        home_hit;
   logic        lim_cw;
   logic        lim_ccw;
   logic        stopped;
   logic        arrived;
   logic [31:0] pos;
   logic        run;
   logic        dir_ccw;
   logic        goto_pos;
   logic [31:0] target;
   logic        busy;
   logic        done;
   modport top (output start, dir_neg, home_hit, lim_cw, lim_ccw, stopped, arrived, pos,
                input  run, dir_ccw, goto_pos, target, busy, done);
   modport seq (input  start, dir_neg, home_hit, lim_cw, lim_ccw, stopped, arrived, pos,
                output run, dir_ccw, goto_pos, target, busy, done);
endinterface : dehm_home_if
`default_nettype wire

// >>> hdl/dehm_homer.sv
`default_nettype none
module dehm_homer (
   input wire logic  clk_sys,
   input wire logic  rst_n,
   dehm_home_if.seq  hi
);
   typedef enum logic [2:0] {H_IDLE, H_SEEK, H_REV, H_STOP, H_RET} dehm_hstate_e;

   dehm_hstate_e state;
   logic         orig_ccw;

   // Limit lying in the present travel direction
   wire lim_ahead = hi.dir_ccw ? hi.lim_ccw : hi.lim_cw;

   // ----------------------------------------
   // Sequencer, independent of any multitask setting
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state       <= H_IDLE;
         orig_ccw    <= 1'b0;
         hi.run      <= 1'b0;
         hi.dir_ccw  <= 1'b0;
         hi.goto_pos <= 1'b0;
         hi.target   <= 32'h0000_0000;
         hi.busy     <= 1'b0;
         hi.done     <= 1'b0;
      end else begin
         hi.goto_pos <= 1'b0;
         hi.done     <= 1'b0;
         case (state)
            H_IDLE: begin
               if (hi.start) begin
                  orig_ccw   <= hi.dir_neg;
                  hi.dir_ccw <= hi.dir_neg;
                  hi.run     <= 1'b1;
                  hi.busy    <= 1'b1;
                  state      <= H_SEEK;
               end
            end
            H_SEEK: begin
               if (hi.home_hit) begin
                  hi.target <= hi.pos;
                  hi.run    <= 1'b0;
                  state     <= H_STOP;
               end else if (lim_ahead) begin
                  hi.dir_ccw <= ~hi.dir_ccw;
                  state      <= H_REV;
               end
            end
            H_REV: begin
               if (lim_ahead) begin
                  hi.dir_ccw <= orig_ccw;
                  state      <= H_SEEK;
               end
            end
            H_STOP: begin
               if (hi.stopped) begin
                  hi.goto_pos <= 1'b1;
                  state       <= H_RET;
               end
            end
            H_RET: begin
               if (hi.arrived) begin
                  hi.busy <= 1'b0;
                  hi.done <= 1'b1;
                  state   <= H_IDLE;
               end
            end
            default: begin
               state <= H_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_HOME_CAPTURE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (state == H_SEEK && hi.home_hit) |=> (hi.target == $past(hi.pos)) && !hi.run)
      else $error("home position not captured with stop");
   AST_DIR_START: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (state == H_IDLE && hi.start) |=> hi.run && (hi.dir_ccw == $past(hi.dir_neg)))
      else $error("homing direction does not follow travel sign");
   AST_REVERSE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (state == H_SEEK && !hi.home_hit && lim_ahead) |=> (hi.dir_ccw != $past(hi.dir_ccw)) && hi.run)
      else $error("no reversal at limit");
   AST_RETURN: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (state == H_STOP && hi.stopped) |=> hi.goto_pos ##1 !hi.goto_pos)
      else $error("return move not issued once");
   COV_REVERSE: cover property (@(posedge clk_sys) disable iff (!rst_n) state == H_REV ##[1:1000] hi.done);
   COV_DIRECT: cover property (@(posedge clk_sys) disable iff (!rst_n) state == H_STOP ##[1:100] hi.done);
endmodule : dehm_homer
`default_nettype wire

// >>> hdl/dehm_top.sv
`default_nettype none
module dehm_top #(
   parameter int          CYC_PER_MS = dehm_pkg::CYC_PER_MS,
   parameter bit          ALT_INPUT  = 1'b0,
   parameter bit          FLEX_IO    = 1'b0,
   parameter logic [15:0] LOW_RES    = 16'h0190
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst_n,
   input  wire logic                 filter_wr,
   input  wire logic [11:0]          filter_hz_in,
   output logic      [11:0]          step_smoothing_filter,
   input  wire logic [15:0]          microstep_resolution,
   input  wire logic                 step_in_raw,
   output logic                      step_out,
   input  wire logic                 seek_home,
   input  wire logic [1:0]           home_point,
   input  wire dehm_pkg::dehm_cond_e home_cond,
   input  wire logic                 travel_length_neg,
   input  wire logic [15:0]          speed_setting,
   input  wire logic [15:0]          speedup_rate,
   input  wire logic [15:0]          slowdown_rate,
   input  wire logic [3:0]           in_raw,
   input  wire logic                 limit_cw_raw,
   input  wire logic                 limit_ccw_raw,
   input  wire logic                 mot_stopped,
   input  wire logic                 mot_arrived,
   input  wire logic [31:0]          position_abs,
   output logic      [15:0]          mot_speed,
   output logic      [15:0]          mot_accel,
   output logic      [15:0]          mot_decel,
   output logic                      mot_run,
   output logic                      mot_dir_ccw,
   output logic                      mot_goto,
   output logic      [31:0]          mot_target,
   output logic                      homing,
   output logic                      home_done,
   input  wire logic                 usage_wr,
   input  wire logic [2:0]           usage_in,
   input  wire logic [1:0]           point_in,
   input  wire logic [3:0]           io_dir_input,
   input  wire logic                 mode_wr,
   input  wire logic [4:0]           control_mode_select,
   input  wire logic                 alarm_wr,
   input  wire logic [1:0]           alarm_in,
   input  wire logic                 main_board_input_three,
   input  wire logic                 alternate_input_three,
   input  wire logic                 motor_on_request,
   input  wire logic                 motor_off_request,
   input  wire logic                 brake_out_on,
   input  wire logic [15:0]          brake_release_delay,
   output logic      [2:0]           enable_usage,
   output logic      [1:0]           enable_point,
   output logic      [1:0]           alarm_reset_input_usage,
   output logic                      speed_change_in,
   output logic                      drive_enabled
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int SW = 9;
   logic [SW-1:0] meta;
   logic [SW-1:0] sync;
   logic [SW-1:0] prev;

   // Two stages on every pin, one more stage for edge detection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         sync <= '0;
         prev <= '0;
      end else begin
         meta <= {step_in_raw, main_board_input_three, alternate_input_three,
                  limit_cw_raw, limit_ccw_raw, in_raw};
         sync <= meta;
         prev <= sync;
      end
   end

   wire [3:0] in_s    = sync[3:0];
   wire [3:0] in_p    = prev[3:0];
   wire       lccw_s  = sync[4];
   wire       lcw_s   = sync[5];
   wire       alt_s   = sync[6];
   wire       main_s  = sync[7];
   wire       step_up = sync[8] && !prev[8];

   // ----------------------------------------
   // Step smoothing filter
   // ----------------------------------------
   logic [23:0] acc;
   logic [7:0]  pend;

   // Filter setting accepts only in-range values
   wire        filt_ok   = filter_wr && (filter_hz_in <= dehm_pkg::FILT_HZ_MAX);
   wire        coarse    = (step_smoothing_filter != dehm_pkg::FILT_HZ_RST) && (microstep_resolution < LOW_RES);
   wire [23:0] ph_inc    = 24'(step_smoothing_filter * dehm_pkg::SUB_STEPS);
   wire [23:0] ph_sum    = acc + ph_inc;
   wire        tick      = ph_sum >= dehm_pkg::PHASE_WRAP;
   wire        emit      = coarse && tick && (pend != 8'h00);
   wire [7:0]  add_sub   = (coarse && step_up) ? dehm_pkg::SUB_STEPS : 8'h00;
   wire [7:0]  next_pend = coarse ? 8'(pend + add_sub - {7'h00, emit}) : 8'h00;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         step_smoothing_filter <= dehm_pkg::FILT_HZ_RST;
      end else if (filt_ok) begin
         step_smoothing_filter <= filter_hz_in;
      end
   end

   // Phase accumulator paces fine pulses at filter rate times sub-steps
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         acc      <= 24'h000000;
         pend     <= 8'h00;
         step_out <= 1'b0;
      end else begin
         acc      <= tick ? 24'(ph_sum - dehm_pkg::PHASE_WRAP) : ph_sum;
         pend     <= next_pend;
         step_out <= coarse ? emit : step_up;
      end
   end

   // ----------------------------------------
   // Homing front end
   // ----------------------------------------
   dehm_home_if hif ();
   dehm_pkg::dehm_cond_e cnd;
   logic [1:0]           hpt;

   wire hs_now = in_s[hpt];
   wire hs_was = in_p[hpt];
   wire start  = seek_home && !hif.busy;

   // Home condition judged on synchronised samples only
   function automatic logic dehm_cond_hit(input dehm_pkg::dehm_cond_e c, input logic now, input logic was);
      case (c)
         dehm_pkg::DEHM_LOW:  dehm_cond_hit = !now;
         dehm_pkg::DEHM_HIGH: dehm_cond_hit = now;
         dehm_pkg::DEHM_FALL: dehm_cond_hit = was && !now;
         dehm_pkg::DEHM_RISE: dehm_cond_hit = !was && now;
         default:             dehm_cond_hit = 1'b0;
      endcase
   endfunction : dehm_cond_hit

   assign hif.start    = start;
   assign hif.dir_neg  = travel_length_neg;
   assign hif.home_hit = dehm_cond_hit(cnd, hs_now, hs_was);
   assign hif.lim_cw   = lcw_s;
   assign hif.lim_ccw  = lccw_s;
   assign hif.stopped  = mot_stopped;
   assign hif.arrived  = mot_arrived;
   assign hif.pos      = position_abs;

   // Latch sensor choice and motion settings at the request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnd       <= dehm_pkg::DEHM_LOW;
         hpt       <= 2'h0;
         mot_speed <= 16'h0000;
         mot_accel <= 16'h0000;
         mot_decel <= 16'h0000;
      end else if (start) begin
         cnd       <= home_cond;
         hpt       <= home_point;
         mot_speed <= speed_setting;
         mot_accel <= speedup_rate;
         mot_decel <= slowdown_rate;
      end
   end

   dehm_homer u_homer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .hi      (hif)
   );

   assign mot_run     = hif.run;
   assign mot_dir_ccw = hif.dir_ccw;
   assign mot_goto    = hif.goto_pos;
   assign mot_target  = hif.target;
   assign homing      = hif.busy;
   assign home_done   = hif.done;

   // ----------------------------------------
   // Enable input claims
   // ----------------------------------------
   logic cm_speed;
   logic en_speed;
   logic man_on;

   wire spd_sel  = (control_mode_select == dehm_pkg::CM_SPD_A) || (control_mode_select == dehm_pkg::CM_SPD_B)
                || (control_mode_select == dehm_pkg::CM_SPD_C) || (control_mode_select == dehm_pkg::CM_SPD_D);
   wire pt_ok    = (point_in == dehm_pkg::PT_ONE) || (point_in == dehm_pkg::PT_THREE);
   wire pt_in    = io_dir_input[2'(point_in - 2'h1)];
   wire code_ok  = FLEX_IO ? ((usage_in >= dehm_pkg::USE_MAIN_OPEN) && (usage_in <= dehm_pkg::USE_NONE)
                            && pt_ok && pt_in)
                           : ((usage_in >= dehm_pkg::USE_MAIN_OPEN)
                            && (usage_in <= (ALT_INPUT ? dehm_pkg::USE_ALT_CLOSED : dehm_pkg::USE_NONE)));
   wire use_ok   = usage_wr && !cm_speed && code_ok;
   wire claim_en = use_ok && (usage_in != dehm_pkg::USE_NONE);
   wire ai_claim = alarm_wr && ((alarm_in == dehm_pkg::AR_OPEN) || (alarm_in == dehm_pkg::AR_CLOSED));

   // Control mode, then alarm use, then enable use take the input
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cm_speed                <= 1'b0;
         en_speed                <= 1'b0;
         enable_usage            <= dehm_pkg::USE_NONE;
         enable_point            <= dehm_pkg::PT_NONE;
         alarm_reset_input_usage <= dehm_pkg::AR_FREE;
      end else if (mode_wr) begin
         cm_speed <= spd_sel;
         en_speed <= spd_sel;
         if (spd_sel) begin
            enable_usage            <= dehm_pkg::USE_NONE;
            alarm_reset_input_usage <= dehm_pkg::AR_FREE;
         end
      end else if (ai_claim) begin
         en_speed                <= 1'b0;
         enable_usage            <= dehm_pkg::USE_NONE;
         alarm_reset_input_usage <= alarm_in;
      end else if (use_ok) begin
         enable_usage <= usage_in;
         enable_point <= FLEX_IO ? point_in : dehm_pkg::PT_NONE;
         if (claim_en) begin
            alarm_reset_input_usage <= dehm_pkg::AR_FREE;
         end
      end
   end

   // ----------------------------------------
   // Drive enable and brake delay
   // ----------------------------------------
   logic [15:0] presc;
   logic [15:0] ms_cnt;
   logic        spd_lvl;

   wire lvl_main  = FLEX_IO ? in_s[2'(enable_point - 2'h1)] : main_s;
   wire want_on   = (enable_usage == dehm_pkg::USE_MAIN_OPEN)   ?  lvl_main :
                    (enable_usage == dehm_pkg::USE_MAIN_CLOSED) ? !lvl_main :
                    (enable_usage == dehm_pkg::USE_ALT_OPEN)    ?  alt_s    :
                    (enable_usage == dehm_pkg::USE_ALT_CLOSED)  ? !alt_s    :
                    man_on;
   wire ms_tick   = presc == 16'(CYC_PER_MS - 1);
   wire hold_brk  = brake_out_on && (ms_cnt < brake_release_delay);

   // Manual on/off latch used only when no input is assigned
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         man_on <= 1'b0;
      end else if (motor_on_request) begin
         man_on <= 1'b1;
      end else if (motor_off_request) begin
         man_on <= 1'b0;
      end
   end

   // Disable waits out the brake delay in whole milliseconds
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         drive_enabled <= 1'b0;
         presc         <= 16'h0000;
         ms_cnt        <= 16'h0000;
      end else if (want_on || !drive_enabled) begin
         drive_enabled <= want_on;
         presc         <= 16'h0000;
         ms_cnt        <= 16'h0000;
      end else if (hold_brk) begin
         presc  <= ms_tick ? 16'h0000 : 16'(presc + 16'h0001);
         ms_cnt <= ms_tick ? 16'(ms_cnt + 16'h0001) : ms_cnt;
      end else begin
         drive_enabled <= 1'b0;
      end
   end

   // Main enable pin doubles as speed-change input in those modes, until an alarm claim takes the input
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         spd_lvl <= 1'b0;
      end else begin
         spd_lvl <= en_speed && main_s;
      end
   end
   assign speed_change_in = spd_lvl;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_FILT_WRITE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      filter_wr |=> (step_smoothing_filter == ($past(filter_hz_in) <= dehm_pkg::FILT_HZ_MAX
                    ? $past(filter_hz_in) : $past(step_smoothing_filter))))
      else $error("filter setting wrong after write");
   AST_SPEED_FORCE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (mode_wr && spd_sel) |=> (enable_usage == dehm_pkg::USE_NONE) && cm_speed)
      else $error("speed mode did not force usage three");
   AST_ALARM_FORCE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (!mode_wr && ai_claim) |=> (enable_usage == dehm_pkg::USE_NONE) ##1 !speed_change_in)
      else $error("alarm claim did not force usage three");
   AST_SPEED_BLOCK: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (cm_speed && usage_wr && !mode_wr && !ai_claim) |=> $stable(enable_usage))
      else $error("usage changed in speed mode");
   AST_OPEN_ENABLE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (enable_usage == dehm_pkg::USE_MAIN_OPEN && lvl_main) |=> drive_enabled)
      else $error("open input did not enable");
   AST_CLOSED_ENABLE: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (enable_usage == dehm_pkg::USE_MAIN_CLOSED && !lvl_main) |=> drive_enabled)
      else $error("closed input did not enable");
   AST_MANUAL_OFF: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (enable_usage == dehm_pkg::USE_NONE && motor_off_request && !motor_on_request && !brake_out_on)
      |=> ##1 !drive_enabled)
      else $error("off request did not disable");
   AST_BRAKE_HOLD: assert property (
      @(posedge clk_sys) disable iff (!rst_n)
      (drive_enabled && !want_on && hold_brk) |=> drive_enabled)
      else $error("drive dropped before brake delay");
   COV_SPEED_MODE: cover property (@(posedge clk_sys) disable iff (!rst_n) mode_wr && spd_sel);
   COV_BRAKE: cover property (@(posedge clk_sys) disable iff (!rst_n) drive_enabled && hold_brk && !want_on);
   COV_SMOOTH: cover property (@(posedge clk_sys) disable iff (!rst_n) emit);
endmodule : dehm_top
`default_nettype wire

// >>> sim/dehm_motion_model.sv
`default_nettype none
module dehm_motion_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        mot_run,
   input  wire logic        mot_goto,
   output logic             mot_stopped,
   output logic             mot_arrived,
   output logic [31:0]      position_abs
);
   timeunit 1ns;
   timeprecision 1ns;
   // At rest whenever not told to run
   assign mot_stopped = !mot_run;
   // Position advances while running; a positioning move lands one cycle later
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         position_abs <= 32'h0000_0100;
         mot_arrived  <= 1'h0;
      end else begin
         position_abs <= position_abs + {31'h0, mot_run};
         mot_arrived  <= mot_goto;
      end
   end
endmodule : dehm_motion_model
`default_nettype wire

// >>> sim/test_drive_enable_and_homing.sv
`default_nettype none
module test_drive_enable_and_homing;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'h0, rst_n = 1'h0, filter_wr = 1'h0, step_in_raw = 1'h0, seek_home = 1'h0;
   logic        usage_wr = 1'h0, mode_wr = 1'h0, motor_on_request = 1'h0, motor_off_request = 1'h0;
   logic        main_board_input_three = 1'h1, travel_length_neg = 1'h1, step_out, mot_run, mot_dir_ccw;
   logic        limit_cw_raw = 1'h0, limit_ccw_raw = 1'h0, alarm_wr = 1'h0, alternate_input_three = 1'h1;
   logic        brake_out_on = 1'h0, speed_change_in;
   logic [1:0]  home_point = 2'h2, alarm_in = 2'h1, alarm_reset_input_usage;
   logic [15:0] speedup_rate = 16'h0045, slowdown_rate = 16'h0067, brake_release_delay = 16'h0000;
   logic [15:0] mot_accel, mot_decel;
   dehm_pkg::dehm_cond_e home_cond = dehm_pkg::DEHM_RISE;
   logic        mot_goto, homing, home_done, drive_enabled, mot_stopped, mot_arrived;
   logic [31:0] position_abs, mot_target, expv;
   logic [15:0] microstep_resolution = 16'h0008, speed_setting = 16'h0123, mot_speed;
   logic [11:0] filter_hz_in = 12'h000, step_smoothing_filter, fv[3] = '{12'h1F4, 12'h9C4, 12'h9C5};
   logic [4:0]  control_mode_select = 5'h00, cms[4] = '{5'h0D, 5'h0E, 5'h11, 5'h12};
   logic [3:0]  in_raw = 4'h0;
   logic [2:0]  usage_in = 3'h1, enable_usage;
   int          mismatches = 0, n_tests = 0, cnt = 0;
   // Standard I/O variant: no flex point is ever supplied
   dehm_top #(.CYC_PER_MS(4)) u_dut (.point_in(2'h0), .io_dir_input(4'h0), .enable_point(), .*);
   dehm_motion_model u_mot (.*);
   // System clock
   always #50 clk_sys = ~clk_sys;
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk
   task automatic pulse(ref logic s);
      s = 1'h1;
      @(negedge clk_sys);
      s = 1'h0;
   endtask : pulse
   task automatic set_use(input logic [2:0] c, input logic p, input logic [2:0] eu, input logic de);
      usage_in = c;
      main_board_input_three = p;
      pulse(usage_wr);
      repeat (5) @(negedge clk_sys);
      chk("usage", eu, enable_usage);
      chk("drive", de, drive_enabled);
   endtask : set_use
   task automatic summarize;
      if (mismatches == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // Reset, then filter, step, enable and homing sequences
   initial begin
      repeat (10) @(negedge clk_sys);
      rst_n = 1'h1;
      chk("usage", 3'h3, enable_usage);
      foreach (fv[i]) begin
         filter_hz_in = fv[i];
         pulse(filter_wr);
         @(negedge clk_sys);
         chk("filter", (fv[i] > 12'h9C4) ? 12'h9C4 : fv[i], step_smoothing_filter);
      end
      step_in_raw = 1'h1;
      repeat (5000) @(negedge clk_sys) cnt += int'(step_out === 1'h1);
      chk("steps", 32'h4, cnt);
      set_use(3'h1, 1'h1, 3'h1, 1'h1);
      set_use(3'h1, 1'h0, 3'h1, 1'h0);
      set_use(3'h2, 1'h0, 3'h2, 1'h1);
      set_use(3'h4, 1'h1, 3'h2, 1'h0);
      pulse(motor_on_request);
      set_use(3'h3, 1'h0, 3'h3, 1'h1);
      pulse(motor_off_request);
      set_use(3'h3, 1'h1, 3'h3, 1'h0);
      foreach (cms[i]) begin
         set_use(3'h1, 1'h1, 3'h1, 1'h1);
         control_mode_select = cms[i];
         pulse(mode_wr);
         set_use(3'h2, 1'h1, 3'h3, 1'h0);
         control_mode_select = 5'h00;
         pulse(mode_wr);
      end
      // Alarm claim takes the input, a later usage write takes it back
      set_use(3'h1, 1'h1, 3'h1, 1'h1);
      alarm_in = 2'h1;
      pulse(alarm_wr);
      @(negedge clk_sys);
      chk("alarm", 2'h1, alarm_reset_input_usage);
      chk("usage", 3'h3, enable_usage);
      set_use(3'h1, 1'h1, 3'h1, 1'h1);
      chk("alarm", 2'h3, alarm_reset_input_usage);
      // Speed mode passes the pin through
      control_mode_select = 5'h0D;
      pulse(mode_wr);
      repeat (3) @(negedge clk_sys);
      chk("spdin", 1'h1, speed_change_in);
      control_mode_select = 5'h00;
      pulse(mode_wr);
      // Brake delay of two milliseconds holds the drive on
      set_use(3'h1, 1'h1, 3'h1, 1'h1);
      brake_out_on = 1'h1;
      brake_release_delay = 16'h0002;
      main_board_input_three = 1'h0;
      repeat (5) @(negedge clk_sys);
      chk("brake", 1'h1, drive_enabled);
      repeat (15) @(negedge clk_sys);
      chk("brake", 1'h0, drive_enabled);
      brake_out_on = 1'h0;
      pulse(seek_home);
      @(negedge clk_sys);
      chk("dir", 1'h1, mot_dir_ccw);
      chk("speed", 16'h0123, mot_speed);
      chk("accel", 16'h0045, mot_accel);
      chk("decel", 16'h0067, mot_decel);
      in_raw = 4'h4;
      for (cnt = 0; cnt < 20 && mot_run === 1'h1; cnt++) begin
         expv = position_abs;
         @(negedge clk_sys);
      end
      chk("target", expv, mot_target);
      for (cnt = 0; cnt < 60 && home_done !== 1'h1; cnt++) @(negedge clk_sys);
      chk("done", 1'h1, home_done);
      // Unsigned travel homes CW; a CW limit first forces a reversal
      in_raw = 4'h0;
      travel_length_neg = 1'h0;
      repeat (4) @(negedge clk_sys);
      pulse(seek_home);
      limit_cw_raw = 1'h1;
      repeat (4) @(negedge clk_sys);
      chk("rev", 1'h1, mot_dir_ccw);
      chk("run", 1'h1, mot_run);
      limit_cw_raw = 1'h0;
      limit_ccw_raw = 1'h1;
      repeat (4) @(negedge clk_sys);
      chk("resume", 1'h0, mot_dir_ccw);
      limit_ccw_raw = 1'h0;
      in_raw = 4'h4;
      for (cnt = 0; cnt < 60 && home_done !== 1'h1; cnt++) @(negedge clk_sys);
      chk("done", 1'h1, home_done);
      summarize();
   end
endmodule : test_drive_enable_and_homing
`default_nettype wire
